// [verilog/byte_rotate_unit.sv]
// Operation
// - left via carry into memory: old carry to bit 0, bit 7 to carry
// - same left rotation into working register; memory byte untouched
// - plain right rotate to memory: bit 0 to bit 7, no flags change
// - plain right rotate into working register; memory and flags unchanged
// - right through carry to memory: old carry to bit 7, bit 0 to carry
// - right through carry into working register; memory byte unchanged
`timescale 1ns/10ps
module byte_rotate_unit
    import bru_pkg::*;
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // instruction request
    input  wire logic        start_i,
    input  wire logic [2:0]  op_i,
    input  wire logic [7:0]  mem_data_i,
    // direct flag / register loads from the rest of the core
    input  wire logic        carry_wr_i,
    input  wire logic        carry_wdata_i,
    input  wire logic        wreg_wr_i,
    input  wire logic [7:0]  wreg_wdata_i,
    // results
    output logic             done_o,
    output logic             illegal_o,
    output logic             mem_wr_o,
    output logic [7:0]       mem_wdata_o,
    output logic [7:0]       working_register_o,
    output logic             carry_o
);

    ////////////////////////////////////////////////////////////////////////
    // request decode

    bru_op_e    req_op;
    logic       req_legal;
    logic       req_take;
    logic       req_refused;

    // what the rotator asks of the held state
    logic [7:0] rot_result;
    logic       rot_carry;
    logic       rot_moves_carry;
    logic       rot_to_mem;
    logic       rot_to_wreg;

    // held state
    logic       carry;
    logic [7:0] working_register;

    // op_i is exactly as wide as the enum, so every code maps to a member
    assign req_op = bru_op_e'(op_i);

    ////////////////////////////////////////////////////////////////////////
    // rotation core: pure logic, so the result and the new carry settle
    // within the cycle in which the request is taken

    bru_rot_if rot ();

    assign rot.op       = req_op;
    assign rot.src      = mem_data_i;
    assign rot.carry_in = carry;

    bru_rotator bru_rotator_inst (
        .rot (rot)
    );

    assign rot_result      = rot.result;
    assign rot_carry       = rot.carry_out;
    assign rot_moves_carry = rot.carry_upd;
    assign rot_to_mem      = rot.to_mem;
    assign rot_to_wreg     = rot.to_wreg;
    assign req_legal       = rot.legal;

    ////////////////////////////////////////////////////////////////////////
    // acceptance: a refused code is only reported and reaches no state

    always_comb begin
        req_take    = 1'b0;
        req_refused = 1'b0;
        if (start_i) begin
            if (req_legal) begin
                req_take = 1'b1;
            end else begin
                req_refused = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // carry select: a rotation that moves the carry wins over a direct load on the same edge,
    // since the instruction is the newer event and its carry must land
    // on the same edge as its result

    logic carry_from_rot;
    logic carry_from_load;

    always_comb begin
        carry_from_rot  = 1'b0;
        carry_from_load = 1'b0;
        if (req_take && rot_moves_carry) begin
            carry_from_rot = 1'b1;
        end else if (carry_wr_i) begin
            carry_from_load = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // working register select, with the same priority as the carry

    logic wreg_from_rot;
    logic wreg_from_load;

    always_comb begin
        wreg_from_rot  = 1'b0;
        wreg_from_load = 1'b0;
        if (req_take && rot_to_wreg) begin
            wreg_from_rot = 1'b1;
        end else if (wreg_wr_i) begin
            wreg_from_load = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory select; nothing else writes the memory through this unit

    logic mem_from_rot;

    always_comb begin
        mem_from_rot = 1'b0;
        if (req_take && rot_to_mem) begin
            mem_from_rot = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // carry flag; plain rotates leave it to the direct load alone

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            carry <= CARRY_RST;
        end else begin
            if (carry_from_rot) begin
                carry <= rot_carry;
            end else if (carry_from_load) begin
                carry <= carry_wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // working register; a load that loses to a rotation is dropped, not
    // deferred, so the core must repeat it if it still wants it

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            working_register <= WREG_RST;
        end else begin
            if (wreg_from_rot) begin
                working_register <= rot_result;
            end else if (wreg_from_load) begin
                working_register <= wreg_wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory write strobe: one cycle, never raised for a working register
    // target, so that byte stays untouched in memory

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mem_wr_o <= 1'b0;
        end else begin
            mem_wr_o <= mem_from_rot;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory write data: holds the last byte written back, so a store
    // that lags the strobe by a cycle still finds it

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mem_wdata_o <= BYTE_ZERO;
        end else begin
            if (mem_from_rot) begin
                mem_wdata_o <= rot_result;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // completion pulse; a nop completes as well

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= req_take;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // refusal pulse

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            illegal_o <= 1'b0;
        end else begin
            illegal_o <= req_refused;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from the held state

    assign working_register_o = working_register;
    assign carry_o            = carry;

endmodule // byte_rotate_unit

// [verilog/bru_pkg.sv]
package bru_pkg;

    // datapath widths
    localparam int unsigned DATA_W = 8;
    localparam int unsigned MSB    = DATA_W - 1;

    // reset values of the held state
    localparam logic [7:0] WREG_RST  = 8'h00;
    localparam logic       CARRY_RST = 1'b0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // operation codes of the unit; all but BRU_ILLEGAL are accepted
    typedef enum logic [2:0] {
        BRU_NOP,
        BRU_ROTATE_LEFT_THRU_CARRY_MEM,
        BRU_ROTATE_LEFT_THRU_CARRY_TO_WREG,
        BRU_ROTATE_RIGHT_MEM,
        BRU_ROTATE_RIGHT_TO_WREG,
        BRU_ROTATE_RIGHT_THRU_CARRY_MEM,
        BRU_ROTATE_RIGHT_THRU_CARRY_TO_WREG,
        BRU_ILLEGAL
    } bru_op_e;

endpackage

// [verilog/bru_rot_if.sv]
`timescale 1ns/10ps
interface bru_rot_if;
    import bru_pkg::*;

    bru_op_e     op;
    logic [7:0]  src;
    logic        carry_in;
    logic [7:0]  result;
    logic        carry_out;
    logic        carry_upd;
    logic        to_mem;
    logic        to_wreg;
    logic        legal;

    modport ctrl (
        output op,
        output src,
        output carry_in,
        input  result,
        input  carry_out,
        input  carry_upd,
        input  to_mem,
        input  to_wreg,
        input  legal
    );

    modport core (
        input  op,
        input  src,
        input  carry_in,
        output result,
        output carry_out,
        output carry_upd,
        output to_mem,
        output to_wreg,
        output legal
    );
endinterface

// [verilog/bru_rotator.sv]
`timescale 1ns/10ps
module bru_rotator
    import bru_pkg::*;
(
    bru_rot_if.core rot
);

    always_comb begin
        rot.result    = BYTE_ZERO;
        rot.carry_out = rot.carry_in;
        rot.carry_upd = 1'b0;
        rot.to_mem    = 1'b0;
        rot.to_wreg   = 1'b0;
        rot.legal     = 1'b1;
        case (rot.op)
            BRU_ROTATE_LEFT_THRU_CARRY_MEM: begin
                rot.result    = {rot.src[MSB-1:0], rot.carry_in};
                rot.carry_out = rot.src[MSB];
                rot.carry_upd = 1'b1;
                rot.to_mem    = 1'b1;
            end
            BRU_ROTATE_LEFT_THRU_CARRY_TO_WREG: begin
                rot.result    = {rot.src[MSB-1:0], rot.carry_in};
                rot.carry_out = rot.src[MSB];
                rot.carry_upd = 1'b1;
                rot.to_wreg   = 1'b1;
            end
            BRU_ROTATE_RIGHT_MEM: begin
                rot.result = {rot.src[0], rot.src[MSB:1]};
                rot.to_mem = 1'b1;
            end
            BRU_ROTATE_RIGHT_TO_WREG: begin
                rot.result  = {rot.src[0], rot.src[MSB:1]};
                rot.to_wreg = 1'b1;
            end
            BRU_ROTATE_RIGHT_THRU_CARRY_MEM: begin
                rot.result    = {rot.carry_in, rot.src[MSB:1]};
                rot.carry_out = rot.src[0];
                rot.carry_upd = 1'b1;
                rot.to_mem    = 1'b1;
            end
            BRU_ROTATE_RIGHT_THRU_CARRY_TO_WREG: begin
                rot.result    = {rot.carry_in, rot.src[MSB:1]};
                rot.carry_out = rot.src[0];
                rot.carry_upd = 1'b1;
                rot.to_wreg   = 1'b1;
            end
            BRU_NOP: begin
                rot.legal = 1'b1;
            end
            default: begin
                rot.legal = 1'b0;
            end
        endcase
    end

endmodule // bru_rotator

// [bench/bru_monitor.sv]
`timescale 1ns/10ps
module bru_monitor
    import bru_pkg::*;
(
    // clock and reset
    input wire logic       clock_i,
    input wire logic       rst_i,
    // requests and loads
    input wire logic       start_i,
    input wire logic [2:0] op_i,
    input wire logic [7:0] mem_data_i,
    input wire logic       carry_wr_i,
    input wire logic       carry_wdata_i,
    input wire logic       wreg_wr_i,
    input wire logic [7:0] wreg_wdata_i,
    // results
    input wire logic       done_o,
    input wire logic       illegal_o,
    input wire logic       mem_wr_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic [7:0] working_register_o,
    input wire logic       carry_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // m and c hold the source byte and the carry seen at the taking edge
    logic [7:0] m, rl, rr, rc, w, d;
    logic [2:0] g;
    logic       c, k;
    always_ff @(posedge clock_i) m <= mem_data_i;
    always_ff @(posedge clock_i) c <= carry_o;
    assign g  = start_i ? op_i : 3'h0;
    assign w  = working_register_o;
    assign d  = mem_wdata_o;
    assign k  = carry_o;
    assign rl = {m[6:0], c};
    assign rr = {m[0], m[7:1]};
    assign rc = {c, m[7:1]};
    property p_ml; g == 3'h1 |=> mem_wr_o && d == rl && k == m[7]; endproperty
    a_ml: assert property (p_ml) else $error("bad left mem");
    property p_wl; g == 3'h2 |=> !mem_wr_o && w == rl && k == m[7]; endproperty
    a_wl: assert property (p_wl) else $error("bad left wreg");
    property p_mr;
        g == 3'h3 && !carry_wr_i |=> mem_wr_o && d == rr && $stable(k);
    endproperty
    a_mr: assert property (p_mr) else $error("bad right mem");
    property p_wr;
        g == 3'h4 && !carry_wr_i |=> !mem_wr_o && w == rr && $stable(k);
    endproperty
    a_wr: assert property (p_wr) else $error("bad right wreg");
    property p_mc; g == 3'h5 |=> mem_wr_o && d == rc && k == m[0]; endproperty
    a_mc: assert property (p_mc) else $error("bad carry mem");
    property p_wc; g == 3'h6 |=> !mem_wr_o && w == rc && k == m[0]; endproperty
    a_wc: assert property (p_wc) else $error("bad carry wreg");
    // memory targets must leave the working register alone
    property p_mw; g[0] && !wreg_wr_i |=> $stable(w); endproperty
    a_mw: assert property (p_mw) else $error("wreg moved");
endmodule // bru_monitor
bind byte_rotate_unit bru_monitor bru_monitor_inst (.*);

// [bench/byte_rotate_unit_bench.sv]
`timescale 1ns/10ps
module byte_rotate_unit_bench;
    logic        clock_i, rst_i, start_i, carry_wr_i, carry_wdata_i, ec;
    logic        wreg_wr_i, done_o, illegal_o, mem_wr_o, carry_o, ed, ei, emw;
    logic [2:0]  op_i;
    logic [7:0]  mem_data_i, wreg_wdata_i, mem_wdata_o, working_register_o;
    logic [7:0]  ew, em;
    logic [8:0]  x;
    logic [31:0] v;
    integer      seed = 32'h702b, fail_count = 0, compares = 0, cyc = 0;
    byte_rotate_unit byte_rotate_unit_inst (.*);
    ////////////////////////////////////////////////////////////////////////
    // returns {new carry, result byte}
    function automatic logic [8:0] rot(input logic [2:0] o,
                                       input logic [7:0] s, input logic c);
        case (o)
            3'h1, 3'h2: rot = {s, c};
            3'h3, 3'h4: rot = {c, s[0], s[7:1]};
            default:    rot = {s[0], c, s[7:1]};
        endcase
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("mismatches %0d of %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            fail_count = fail_count + 1;
            results;
        end
    end
    initial begin
        {rst_i, start_i, carry_wr_i, carry_wdata_i, wreg_wr_i} = 5'h10;
        {op_i, mem_data_i, wreg_wdata_i} = 19'h0;
        {ew, em, ec, ed, ei, emw} = 20'h0;
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 2000; i++) begin
            @(posedge clock_i);
            check({5'h0, done_o, illegal_o, mem_wr_o},
                  {5'h0, ed, ei, emw});
            check(mem_wdata_o, em);
            check(working_register_o, ew);
            check(8'(carry_o), 8'(ec));
            // rotation uses the old carry, then wins over a same-edge load
            x = rot(op_i, mem_data_i, ec);
            if (carry_wr_i) ec = carry_wdata_i;
            if (wreg_wr_i) ew = wreg_wdata_i;
            ed = start_i && op_i != 3'h7;
            ei = start_i && op_i == 3'h7;
            emw = ed && op_i[0];
            if (ed && op_i != 3'h0) begin
                if (op_i < 3'h3 || op_i > 3'h4) ec = x[8];
                if (op_i[0]) em = x[7:0];
                else ew = x[7:0];
            end
            if (rst_i) {ew, em, ec, ed, ei, emw} = 20'h0;
            // first 16: every code back to back on edge bytes
            v = $random(seed);
            v[0] = v[0] | (i < 16);
            start_i <= v[0];
            op_i <= (i < 16) ? 3'(i) : v[3:1];
            mem_data_i <= (i < 16) ? (i[3] ? 8'h80 : 8'h01) : v[11:4];
            carry_wr_i <= v[12];
            carry_wdata_i <= v[13];
            wreg_wr_i <= v[14];
            wreg_wdata_i <= v[22:15];
            // a short reset in mid-run, with requests still arriving
            rst_i <= i >= 1000 && i < 1003;
        end
        results;
    end
endmodule // byte_rotate_unit_bench
